// ---- bcr_regs.sv ----
// Word decode for the software command word, boost configuration and slew settings.
// Assumes word_i/word_valid_i come from serial logic on clk_sys_i; osc_i is a
// free-running 13 MHz oscillator pin, synchronised here; wdog inputs are on clk_sys_i.
`include "bcr_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module bcr_regs
    import bcr_pkg::*;
#(
    parameter int WDOG_W = 24,
    parameter int NCH = 4
) (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic osc_i,
    input wire logic [15:0] word_i,
    input wire logic word_valid_i,
    input wire logic [1:0] slew_ch_i,
    input wire logic wdog_en_i,
    input wire logic [WDOG_W-1:0] wdog_timeout_i,
    output logic user_toggle_o,
    output logic soft_reset_o,
    output logic alert_o,
    output logic boost_comp_pin_o,
    output logic [1:0] boost_phase_arrangement_o,
    output logic [1:0] boost_voltage_ceiling_o,
    output logic [3:0] boost_clk_o,
    output bcr_slew_s [NCH-1:0] slew_cfg_o,
    output logic [15:0] boost_cfg_rd_o
);

    // Divider count for a rate code; unused code folds onto the default rate
    function automatic logic [5:0] rate_div(input logic [1:0] code);
        case (code)
            2'h0: rate_div = `BCR_DIV_250K;
            2'h2: rate_div = `BCR_DIV_650K;
            default: rate_div = `BCR_DIV_410K;
        endcase
    endfunction

    logic is_sw, is_boost, is_slew;
    assign is_sw = word_valid_i && (word_i[15:13] == `BCR_PFX_SW);
    assign is_boost = word_valid_i && (word_i[15:13] == `BCR_PFX_BOOST);
    assign is_slew = word_valid_i && (word_i[15:13] == `BCR_PFX_SLEW);

    logic reset_hit, refresh_hit;
    assign reset_hit = is_sw && (word_i[11:0] == `BCR_KEY_RESET);
    assign refresh_hit = is_sw && (word_i[11:0] == `BCR_KEY_REFRESH);

    // Oscillator pin synchroniser; stage one feeds only stage two
    logic osc_s1, osc_s2, osc_s3;
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            osc_s1 <= 1'h0;
            osc_s2 <= 1'h0;
            osc_s3 <= 1'h0;
        end else begin
            osc_s1 <= osc_i;
            osc_s2 <= osc_s1;
            osc_s3 <= osc_s2;
        end
    end
    logic osc_rise;
    assign osc_rise = osc_s2 && !osc_s3;

    // Configuration state
    bcr_boost_s boost, next_boost;
    bcr_slew_s [NCH-1:0] slew, next_slew;
    logic toggle, next_toggle;
    always_comb begin
        next_boost = boost;
        next_slew = slew;
        next_toggle = toggle;
        if (reset_hit) begin
            // Key resets all configuration, toggle included
            next_boost = '{`BCR_RST_COMP, `BCR_RST_PHASE, `BCR_RST_RATE, `BCR_RST_VMAX};
            next_slew = '0;
            next_toggle = 1'h0;
        end else begin
            if (is_sw)
                next_toggle = word_i[`BCR_BIT_TOGGLE];
            if (is_boost) begin
                next_boost.comp_bypass = word_i[`BCR_BIT_COMP];
                next_boost.phase = word_i[5:4];
                next_boost.rate = word_i[3:2];
                next_boost.vmax = word_i[1:0];
            end
            if (is_slew)
                next_slew[slew_ch_i] = '{word_i[12], word_i[6:3], word_i[2:0]};
        end
    end
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            boost <= '{`BCR_RST_COMP, `BCR_RST_PHASE, `BCR_RST_RATE, `BCR_RST_VMAX};
            slew <= '0;
            toggle <= 1'h0;
        end else begin
            boost <= next_boost;
            slew <= next_slew;
            toggle <= next_toggle;
        end
    end

    // Watchdog; counts only while enabled, refresh restarts it
    logic [WDOG_W-1:0] wd_cnt, next_wd_cnt;
    logic alert, next_alert;
    always_comb begin
        next_wd_cnt = wd_cnt;
        next_alert = alert;
        if (!wdog_en_i || refresh_hit || reset_hit) begin
            next_wd_cnt = '0;
            next_alert = reset_hit ? 1'h0 : alert && wdog_en_i;
        end else if (wd_cnt >= wdog_timeout_i) begin
            next_alert = 1'h1;
        end else begin
            next_wd_cnt = wd_cnt + 1'h1;
        end
    end
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wd_cnt <= '0;
            alert <= 1'h0;
        end else begin
            wd_cnt <= next_wd_cnt;
            alert <= next_alert;
        end
    end

    // Switching clock: divide oscillator edges, then spread four phases
    // A half-period toggle gives the opposite edge; quarter steps give 90 degrees
    logic [5:0] div_cnt, next_div_cnt;
    logic [1:0] quad, next_quad;
    always_comb begin
        next_div_cnt = div_cnt;
        next_quad = quad;
        if (osc_rise) begin
            if (div_cnt >= (rate_div(boost.rate) >> 2) - 6'h1) begin
                next_div_cnt = '0;
                next_quad = quad + 2'h1;
            end else begin
                next_div_cnt = div_cnt + 6'h1;
            end
        end
    end
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            div_cnt <= '0;
            quad <= '0;
        end else begin
            div_cnt <= next_div_cnt;
            quad <= next_quad;
        end
    end

    // Per-channel phase select
    logic base, inv, q90;
    logic [3:0] next_clk;
    assign base = !quad[1];
    assign inv = quad[1];
    assign q90 = (quad == 2'h1) || (quad == 2'h2);
    always_comb begin
        case (boost.phase)
            2'h0: next_clk = {4{base}};
            2'h1: next_clk = {inv, inv, base, base};
            2'h2: next_clk = {inv, base, inv, base};
            2'h3: next_clk = {!q90, inv, q90, base};
            default: next_clk = {4{base}};
        endcase
    end

    // Registered outputs
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            user_toggle_o <= 1'h0;
            soft_reset_o <= 1'h0;
            alert_o <= 1'h0;
            boost_comp_pin_o <= `BCR_RST_COMP;
            boost_phase_arrangement_o <= `BCR_RST_PHASE;
            boost_voltage_ceiling_o <= `BCR_RST_VMAX;
            boost_clk_o <= '0;
            slew_cfg_o <= '0;
            boost_cfg_rd_o <= '0;
        end else begin
            user_toggle_o <= toggle;
            soft_reset_o <= reset_hit;
            alert_o <= alert;
            boost_comp_pin_o <= boost.comp_bypass;
            boost_phase_arrangement_o <= boost.phase;
            boost_voltage_ceiling_o <= boost.vmax;
            boost_clk_o <= next_clk;
            slew_cfg_o <= slew;
            boost_cfg_rd_o <= {9'h0, boost};
        end
    end

    a_toggle_copy: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        is_sw && !reset_hit |=> ##1 user_toggle_o == $past(word_i[12], 2))
        else $error("toggle bit not mirrored");
    a_reset_pulse: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        reset_hit |=> soft_reset_o ##1 (boost_cfg_rd_o[1:0] == `BCR_RST_VMAX))
        else $error("reset key missed");
    a_boost_decode: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        is_boost |=> ##1 boost_cfg_rd_o[6:0] == $past(word_i[6:0], 2))
        else $error("boost word not stored");
    a_comp_pin: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        is_boost |=> ##1 boost_comp_pin_o == $past(word_i[6], 2))
        else $error("compensation select wrong");
    a_vmax_field: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        is_boost |=> ##1 boost_voltage_ceiling_o == $past(word_i[1:0], 2))
        else $error("voltage ceiling wrong");
    a_other_ignored: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        !is_boost && !reset_hit |=> $stable(boost))
        else $error("config changed by other word");
    a_alert_wdog: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        !wdog_en_i ##1 !wdog_en_i |-> ##1 !alert_o)
        else $error("alert without watchdog");
    a_refresh_clear: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        refresh_hit |=> wd_cnt == '0)
        else $error("refresh did not restart count");
    a_phase_same: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        boost.phase == 2'h0 |=> boost_clk_o inside {4'h0, 4'hf})
        else $error("phases differ in mode 00");
    a_rate_fold: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        boost.rate == 2'h3 && osc_rise && div_cnt == 6'h7 |=> div_cnt == 6'h0)
        else $error("code 11 not default rate");

endmodule // bcr_regs
`default_nettype wire

// ---- bcr_cfg.svh ----
// Constants for the soft-reset and boost-converter command decode block.
// Assumes the serial front end delivers whole 16-bit data words with a strobe.
// How it works
// - Prefix 100 selects the software command word
// - Toggle bit D12 copied into status bit
// - Low twelve bits 0x555 cause software reset
// - Missed refresh while enabled raises alert output
// - Prefix 011 selects boost config; D12-D7 ignored
// - D6 picks internal or bypassed compensation resistor
// - D5:D4 sets phase arrangement of four converters
// - D3:D2 sets switching rate from 13 MHz
// - D1:D0 sets boost voltage ceiling
// - Each channel keeps own slew-rate setting
`ifndef BCR_CFG_SVH
`define BCR_CFG_SVH
`define BCR_PFX_SW 3'h4
`define BCR_PFX_BOOST 3'h3
`define BCR_PFX_SLEW 3'h0
`define BCR_KEY_RESET 12'h555
`define BCR_KEY_REFRESH 12'h195
`define BCR_BIT_TOGGLE 12
`define BCR_BIT_COMP 6
`define BCR_RST_COMP 1'h0
`define BCR_RST_PHASE 2'h0
`define BCR_RST_RATE 2'h1
`define BCR_RST_VMAX 2'h0
`define BCR_OSC_HZ 13000000
`define BCR_DIV_250K 6'h34
`define BCR_DIV_410K 6'h20
`define BCR_DIV_650K 6'h14
`endif

// ---- bcr_pkg.sv ----
// Types for the soft-reset and boost-converter command decode block.
// Assumes bcr_cfg.svh is compiled alongside.
package bcr_pkg;
    typedef struct packed {
        logic comp_bypass;
        logic [1:0] phase;
        logic [1:0] rate;
        logic [1:0] vmax;
    } bcr_boost_s;
    typedef struct packed {
        logic enable;
        logic [3:0] clock_sel;
        logic [2:0] step;
    } bcr_slew_s;
endpackage

// ---- bcr_host_model.sv ----
// Host stand-in that hands whole command words to the decode block.
// Assumes the bench calls its tasks; words change on falling clock edges.
`timescale 1ns/10ps
`default_nettype none
module bcr_host_model (
    input wire logic clk_sys_i,
    output logic [15:0] word_o,
    output logic word_valid_o
);
    // Idle bus at time zero
    initial begin
        word_o = 16'h0000;
        word_valid_o = 1'b0;
    end
    // One-cycle strobe; the word is inverted afterwards so stale data never matches
    task automatic send(input logic [15:0] w);
        @(negedge clk_sys_i);
        word_o = w;
        word_valid_o = 1'b1;
        @(negedge clk_sys_i);
        word_valid_o = 1'b0;
        word_o = ~w;
    endtask
    // Refresh key in the command word keeps the watchdog quiet
    task automatic refresh();
        send({3'h4, 1'b0, 12'h195});
    endtask
endmodule // bcr_host_model
`default_nettype wire

// ---- bcr_regs_bench.sv ----
// Self-checking bench for the command-word decode block.
// Assumes bcr_pkg, bcr_cfg.svh and bcr_host_model are compiled first.
`timescale 1ns/10ps
`default_nettype none
module bcr_regs_bench;
    import bcr_pkg::*;
    localparam real OSC_NS = 76.92;
    logic clk_sys_i, resetn_i, osc_i, word_valid_i, wdog_en_i, user_toggle_o, soft_reset_o, alert_o;
    logic boost_comp_pin_o;
    logic [15:0] word_i, boost_cfg_rd_o;
    logic [1:0] slew_ch_i, boost_phase_arrangement_o, boost_voltage_ceiling_o;
    logic [23:0] wdog_timeout_i;
    logic [3:0] boost_clk_o, e;
    bcr_slew_s [3:0] slew_cfg_o;
    int bad_count = 0;
    int check_count = 0;
    int n;
    int exp_n [4] = '{52, 32, 20, 32};
    real t0;
    bcr_regs dut (.clk_sys_i, .resetn_i, .osc_i, .word_i, .word_valid_i, .slew_ch_i, .wdog_en_i, .wdog_timeout_i,
        .user_toggle_o, .soft_reset_o, .alert_o, .boost_comp_pin_o, .boost_phase_arrangement_o,
        .boost_voltage_ceiling_o, .boost_clk_o, .slew_cfg_o, .boost_cfg_rd_o);
    bcr_host_model host (.clk_sys_i, .word_o(word_i), .word_valid_o(word_valid_i));
    // System clock; the oscillator runs apart from it in phase
    initial begin
        clk_sys_i = 1'b0;
        forever #12.5 clk_sys_i = ~clk_sys_i;
    end
    initial begin
        osc_i = 1'b0;
        #3.1;
        forever #38.46 osc_i = ~osc_i;
    end
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Outputs settle two edges after the word is taken
    task automatic put(input logic [15:0] w);
        host.send(w);
        repeat (2) @(negedge clk_sys_i);
    endtask
    // Four periods averaged so synchroniser jitter stays below half a count
    task automatic period(output int cnt);
        @(posedge boost_clk_o[0]);
        @(posedge boost_clk_o[0]);
        t0 = $realtime;
        repeat (4) @(posedge boost_clk_o[0]);
        cnt = $rtoi(($realtime - t0) / (4.0 * OSC_NS) + 0.5);
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // Hang guard, far beyond the expected run of about 3000 cycles
    initial begin
        #1000000;
        bad_count++;
        conclude();
    end
    // Main sequence
    initial begin
        resetn_i = 1'b0;
        slew_ch_i = 2'h0;
        wdog_en_i = 1'b0;
        wdog_timeout_i = 24'h00000a;
        repeat (20) @(negedge clk_sys_i);
        resetn_i = 1'b1;
        repeat (2) @(negedge clk_sys_i);
        chk("cfg", 16'h0004, boost_cfg_rd_o);
        chk("comp", 16'h0000, {15'h0, boost_comp_pin_o});
        for (int i = 0; i < 4; i++) begin
            put({3'h3, 6'h3f, i[0], i[1:0], 2'h1, i[1:0]});
            chk("cfg", {9'h0, i[0], i[1:0], 2'h1, i[1:0]}, boost_cfg_rd_o);
            chk("comp", {15'h0, i[0]}, {15'h0, boost_comp_pin_o});
            chk("phase", {14'h0, i[1:0]}, {14'h0, boost_phase_arrangement_o});
            chk("ceiling", {14'h0, i[1:0]}, {14'h0, boost_voltage_ceiling_o});
        end
        put(16'hffff);
        chk("cfg", 16'h0077, boost_cfg_rd_o);
        $display("test boost fields done");
        for (int r = 0; r < 4; r++) begin
            put({3'h3, 9'h000, r[1:0], 2'h0});
            period(n);
            chk("period", exp_n[r][15:0], n[15:0]);
        end
        for (int p = 0; p < 4; p++) begin
            put({3'h3, 7'h00, p[1:0], 2'h2, 2'h0});
            n = 0;
            repeat (8) begin
                repeat (7) @(negedge clk_sys_i);
                e = (p == 0) ? {4{boost_clk_o[0]}} : (p == 1) ? {~boost_clk_o[0], ~boost_clk_o[0],
                    boost_clk_o[0], boost_clk_o[0]} : (p == 2) ? {~boost_clk_o[0], boost_clk_o[0],
                    ~boost_clk_o[0], boost_clk_o[0]} : {~boost_clk_o[1], ~boost_clk_o[0], boost_clk_o[1], boost_clk_o[0]};
                n += int'(boost_clk_o[1] != boost_clk_o[0]);
                chk("clk phase", {12'h0, e}, {12'h0, boost_clk_o});
            end
            // In quadrature B leads or lags A part of each period only
            if (p == 3) begin
                chk("quadrature", 16'h0001, {15'h0, (n > 0 && n < 8)});
            end
        end
        $display("test switching clocks done");
        for (int c = 0; c < 4; c++) begin
            slew_ch_i = c[1:0];
            put({3'h0, c[0], 5'h1f, 4'(c + 5), 3'(7 - c)});
        end
        for (int c = 0; c < 4; c++) begin
            chk("slew", {8'h0, c[0], 4'(c + 5), 3'(7 - c)}, {8'h0, slew_cfg_o[c]});
        end
        put({3'h4, 1'b1, 12'h000});
        chk("toggle", 16'h0001, {15'h0, user_toggle_o});
        put({3'h4, 1'b0, 12'h000});
        chk("toggle", 16'h0000, {15'h0, user_toggle_o});
        $display("test toggle and slew done");
        wdog_en_i = 1'b1;
        repeat (4) begin
            host.refresh();
            repeat (4) @(negedge clk_sys_i);
            chk("alert", 16'h0000, {15'h0, alert_o});
        end
        repeat (14) @(negedge clk_sys_i);
        chk("alert", 16'h0001, {15'h0, alert_o});
        // A late refresh restarts the count but the fault stays latched
        host.refresh();
        repeat (2) @(negedge clk_sys_i);
        chk("alert", 16'h0001, {15'h0, alert_o});
        wdog_en_i = 1'b0;
        repeat (2) @(negedge clk_sys_i);
        chk("alert", 16'h0000, {15'h0, alert_o});
        $display("test watchdog done");
        put({3'h4, 1'b1, 12'h000});
        host.send({3'h4, 1'b0, 12'h555});
        // The pulse already stands when send returns, so sample from here
        n = int'(soft_reset_o);
        repeat (3) begin
            @(negedge clk_sys_i);
            n += int'(soft_reset_o);
        end
        chk("reset pulse", 16'h0001, n[15:0]);
        chk("toggle", 16'h0000, {15'h0, user_toggle_o});
        chk("cfg", 16'h0004, boost_cfg_rd_o);
        $display("test soft reset done");
        conclude();
    end
endmodule // bcr_regs_bench
`default_nettype wire
